// ===== lta_cfg.svh
// Offsets, field positions, reset values and counts of the light alert block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word-aligned registers.
`ifndef LTA_CFG_SVH
`define LTA_CFG_SVH

// Register byte offsets
`define LTA_OFF_RESULT 8'h00
`define LTA_OFF_SETUP 8'h04
`define LTA_OFF_LOW 8'h08
`define LTA_OFF_HIGH 8'h0c
`define LTA_OFF_STAT 8'h10
`define LTA_OFF_MASK 8'h14
`define LTA_OFF_IDENT 8'h18

// Fields of alert_and_range_setup
`define LTA_RANGE_HI 15
`define LTA_RANGE_LO 12
`define LTA_OVER_BIT 6
`define LTA_UNDER_BIT 5
`define LTA_STICKY_BIT 4
`define LTA_INV_BIT 3
`define LTA_EMASK_BIT 2
`define LTA_FSEL_HI 1
`define LTA_FSEL_LO 0

// Result and limit word layout
`define LTA_EXP_HI 15
`define LTA_EXP_LO 12
`define LTA_MAN_HI 11
`define LTA_RANGE_AUTO 4'hc
`define LTA_EXP_ZERO 4'h0

// Reset values
`define LTA_RANGE_RST 4'hc
`define LTA_STICKY_RST 1'b1
`define LTA_INV_RST 1'b0
`define LTA_EMASK_RST 1'b0
`define LTA_FSEL_RST 2'h0
`define LTA_LOW_RST 16'h0000
`define LTA_HIGH_RST 16'hbfff

// Interrupt status bits
`define LTA_IRQ_OVER 0
`define LTA_IRQ_UNDER 1
`define LTA_IRQ_DONE 2
`define LTA_IRQ_W 3

// Block identity, value is arbitrary
`define LTA_IDENT_VAL 32'h0000a5c3

`endif

// ===== lta_pkg.sv
// Types of the light alert block.
// Assumes lta_cfg.svh is on the include path.
`include "lta_cfg.svh"

package lta_pkg;
    typedef struct packed {
        logic wait_bus;
        logic [31:0] rdata;
        logic [15:0] result;
        logic [3:0] range_number;
        logic sticky;
        logic inv;
        logic emask;
        logic [1:0] fault_count_sel;
        logic [15:0] low;
        logic [15:0] high;
        logic over;
        logic under;
        logic [`LTA_IRQ_W-1:0] irq_stat;
        logic [`LTA_IRQ_W-1:0] irq_mask;
        logic irq;
        logic alert_oe;
    } lta_state_t;

    typedef struct packed {
        logic [3:0] count;
    } lta_fault_state_t;
endpackage

// ===== lta_lux_scale.sv
// Converts a result or limit word (exponent, 12-bit mantissa) to a common lux scale.
// Assumes the word follows the result register layout; purely combinational.
`include "lta_cfg.svh"
module lta_lux_scale
    import lta_pkg::*;
(
    // Word in
    input wire logic [15:0] word,
    // Scaled value out
    output logic [26:0] lux
);
    always_comb begin
        lux = {15'h0000, word[`LTA_MAN_HI:0]} << word[`LTA_EXP_HI:`LTA_EXP_LO];
    end
endmodule

// ===== lta_fault_count.sv
// Consecutive fault counter for one limit; trip pulses when the selected count is met.
// Assumes sample is a one-cycle pulse per conversion on the same clock.
module lta_fault_count
    import lta_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Per conversion
    input wire logic sample,
    input wire logic fault,
    input wire logic [1:0] sel,
    // Count reached
    output logic trip
);
    lta_fault_state_t st;
    lta_fault_state_t next_st;
    logic [3:0] need;

    always_comb begin
        need = 4'h1 << sel;
        next_st = st;
        trip = 1'b0;
        if (sample) begin
            if (fault) begin
                if (st.count + 4'h1 >= need) begin
                    trip = 1'b1;
                    next_st.count = need;
                end else begin
                    next_st.count = st.count + 4'h1;
                end
            end else begin
                next_st.count = 4'h0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    restart_on_pass_a: assert property (sample && !fault |=> st.count == 4'h0)
        else $error("fault count not restarted");
    trip_at_need_a: assert property (trip |-> st.count + 4'h1 >= (4'h1 << sel))
        else $error("trip before selected count");
endmodule

// ===== lta_top.sv
// Threshold compare and alert reporting of an ambient light sensor, Avalon-MM slave.
// Assumes result and result_valid come from the conversion engine on core_clk.
// Operation
// - The over flag sets once the result exceeds the high limit for the selected count.
// - With sticky mode off, alert and both flags follow the present comparison by themselves.
// - With sticky mode on (reset value), alert and flags hold until software clears them.
// - With invert off, an alert pulls the alert pin low.
// - With invert on, an alert releases the pin and no alert drives it low.
// - With exponent mask on and a manual range, the read result exponent is zero.
// - Masking touches only the read value; comparisons use the raw result.
// - Fault count codes 0 to 3 need 1, 2, 4 or 8 consecutive faults; reset selects 1.
// - Result and limits are scaled to lux before being compared.
`include "lta_cfg.svh"
module lta_top
    import lta_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Conversion engine
    input wire logic [15:0] result,
    input wire logic result_valid,
    // Status
    output logic over_threshold_hit,
    output logic under_threshold_hit,
    output logic irq,
    // Open-drain alert pin
    output logic alert_out,
    output logic alert_oe
);
    lta_state_t st;
    lta_state_t next_st;
    logic [26:0] res_lux;
    logic [26:0] low_lux;
    logic [26:0] high_lux;
    logic over_fault;
    logic under_fault;
    logic over_trip;
    logic under_trip;
    logic req;
    logic accept;
    logic clear_evt;
    logic [`LTA_IRQ_W-1:0] irq_set;

    // Merge a 16-bit register with the enabled low byte lanes of a write
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] v;
        v = old;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction

    // Read value of a register, zero for an unmapped address
    function automatic logic [31:0] rd_mux(input lta_state_t s, input logic [7:0] a);
        logic [31:0] v;
        logic [3:0] e;
        v = 32'h0000_0000;
        e = s.result[`LTA_EXP_HI:`LTA_EXP_LO];
        if (s.emask && s.range_number < `LTA_RANGE_AUTO) begin
            e = `LTA_EXP_ZERO;
        end
        case (a)
            `LTA_OFF_RESULT: begin
                v[15:0] = {e, s.result[`LTA_MAN_HI:0]};
            end
            `LTA_OFF_SETUP: begin
                v[`LTA_RANGE_HI:`LTA_RANGE_LO] = s.range_number;
                v[`LTA_OVER_BIT] = s.over;
                v[`LTA_UNDER_BIT] = s.under;
                v[`LTA_STICKY_BIT] = s.sticky;
                v[`LTA_INV_BIT] = s.inv;
                v[`LTA_EMASK_BIT] = s.emask;
                v[`LTA_FSEL_HI:`LTA_FSEL_LO] = s.fault_count_sel;
            end
            `LTA_OFF_LOW: begin
                v[15:0] = s.low;
            end
            `LTA_OFF_HIGH: begin
                v[15:0] = s.high;
            end
            `LTA_OFF_STAT: begin
                v[`LTA_IRQ_W-1:0] = s.irq_stat;
            end
            `LTA_OFF_MASK: begin
                v[`LTA_IRQ_W-1:0] = s.irq_mask;
            end
            `LTA_OFF_IDENT: begin
                v = `LTA_IDENT_VAL;
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    // Lux scaling of the raw result and both limits
    lta_lux_scale u_res_scale (
        .word(result),
        .lux(res_lux)
    );
    lta_lux_scale u_low_scale (
        .word(st.low),
        .lux(low_lux)
    );
    lta_lux_scale u_high_scale (
        .word(st.high),
        .lux(high_lux)
    );

    assign over_fault = res_lux > high_lux;
    assign under_fault = res_lux < low_lux;

    // Consecutive fault counters
    lta_fault_count u_over_count (
        .core_clk(core_clk),
        .rstn(rstn),
        .sample(result_valid),
        .fault(over_fault),
        .sel(st.fault_count_sel),
        .trip(over_trip)
    );
    lta_fault_count u_under_count (
        .core_clk(core_clk),
        .rstn(rstn),
        .sample(result_valid),
        .fault(under_fault),
        .sel(st.fault_count_sel),
        .trip(under_trip)
    );

    always_comb begin
        next_st = st;
        req = read || write;
        accept = req && !st.wait_bus;
        clear_evt = accept && read && address == `LTA_OFF_SETUP && st.sticky;
        irq_set = '0;

        // One wait cycle per access, then the answer
        next_st.wait_bus = !(req && st.wait_bus);
        if (req && st.wait_bus && read) begin
            next_st.rdata = rd_mux(st, address);
        end

        if (accept && write) begin
            case (address)
                `LTA_OFF_SETUP: begin
                    if (byteenable[1]) begin
                        next_st.range_number = writedata[`LTA_RANGE_HI:`LTA_RANGE_LO];
                    end
                    if (byteenable[0]) begin
                        next_st.sticky = writedata[`LTA_STICKY_BIT];
                        next_st.inv = writedata[`LTA_INV_BIT];
                        next_st.emask = writedata[`LTA_EMASK_BIT];
                        next_st.fault_count_sel = writedata[`LTA_FSEL_HI:`LTA_FSEL_LO];
                    end
                end
                `LTA_OFF_LOW: begin
                    next_st.low = merge16(st.low, writedata, byteenable);
                end
                `LTA_OFF_HIGH: begin
                    next_st.high = merge16(st.high, writedata, byteenable);
                end
                `LTA_OFF_STAT: begin
                    if (byteenable[0]) begin
                        next_st.irq_stat = st.irq_stat & ~writedata[`LTA_IRQ_W-1:0];
                    end
                end
                `LTA_OFF_MASK: begin
                    if (byteenable[0]) begin
                        next_st.irq_mask = writedata[`LTA_IRQ_W-1:0];
                    end
                end
                default: begin
                    next_st.range_number = st.range_number;
                end
            endcase
        end

        // Raw result is kept; masking applies on read only
        if (result_valid) begin
            next_st.result = result;
            irq_set[`LTA_IRQ_DONE] = 1'b1;
        end

        // Flags: a trip always wins over any clear in the same cycle
        if (over_trip) begin
            next_st.over = 1'b1;
            irq_set[`LTA_IRQ_OVER] = 1'b1;
        end else if (!st.sticky && result_valid && !over_fault) begin
            next_st.over = 1'b0;
        end else if (clear_evt) begin
            next_st.over = 1'b0;
        end
        if (under_trip) begin
            next_st.under = 1'b1;
            irq_set[`LTA_IRQ_UNDER] = 1'b1;
        end else if (!st.sticky && result_valid && !under_fault) begin
            next_st.under = 1'b0;
        end else if (clear_evt) begin
            next_st.under = 1'b0;
        end

        next_st.irq_stat = next_st.irq_stat | irq_set;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
        // Open-drain enable: drive low while alert unless inverted
        next_st.alert_oe = (next_st.over || next_st.under) ^ next_st.inv;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '0;
            st.wait_bus <= 1'b1;
            st.range_number <= `LTA_RANGE_RST;
            st.sticky <= `LTA_STICKY_RST;
            st.inv <= `LTA_INV_RST;
            st.emask <= `LTA_EMASK_RST;
            st.fault_count_sel <= `LTA_FSEL_RST;
            st.low <= `LTA_LOW_RST;
            st.high <= `LTA_HIGH_RST;
            st.alert_oe <= `LTA_INV_RST;
        end else begin
            st <= next_st;
        end
    end

    assign readdata = st.rdata;
    assign waitrequest = st.wait_bus;
    assign over_threshold_hit = st.over;
    assign under_threshold_hit = st.under;
    assign irq = st.irq;
    assign alert_out = 1'b0;
    assign alert_oe = st.alert_oe;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Flags and status set on a trip, done status set on each conversion
    under_flag_set_a: assert property (under_trip |=> st.under)
        else $error("under flag not set after trip");
    under_status_set_a: assert property (under_trip |=> st.irq_stat[`LTA_IRQ_UNDER])
        else $error("under status not set after trip");
    over_flag_set_a: assert property (over_trip |=> st.over && st.irq_stat[`LTA_IRQ_OVER])
        else $error("over flag or status not set after trip");
    status_done_a: assert property (result_valid |=> st.irq_stat[`LTA_IRQ_DONE])
        else $error("conversion done status not set");

    // Transparent and latched reporting
    hyst_track_a: assert property (!st.sticky && result_valid && !over_fault
                                   |=> !st.over)
        else $error("transparent over flag did not follow compare");
    under_track_a: assert property (!st.sticky && result_valid && !under_fault
                                    |=> !st.under)
        else $error("transparent under flag did not follow compare");
    latch_hold_a: assert property (st.sticky && st.over && !clear_evt |=> st.over)
        else $error("latched over flag dropped without clear");
    under_latch_a: assert property (st.sticky && st.under && !clear_evt |=> st.under)
        else $error("latched under flag dropped without clear");
    clear_drops_a: assert property (clear_evt && !over_trip && !under_trip
                                    |=> !st.over && !st.under)
        else $error("clearing read left a flag set");

    // Alert pin drive
    alert_low_a: assert property (!st.inv && (st.over || st.under) |-> st.alert_oe)
        else $error("alert not driven low");
    idle_release_a: assert property (!st.inv && !(st.over || st.under) |-> !st.alert_oe)
        else $error("alert pin driven without alert");
    alert_invert_a: assert property (st.inv |-> st.alert_oe == !(st.over || st.under))
        else $error("inverted alert drive wrong");

    // Result read path
    exp_mask_read_a: assert property (read && st.wait_bus && address == `LTA_OFF_RESULT
                                      && st.emask && st.range_number < `LTA_RANGE_AUTO
                                      ##1 !waitrequest
                                      |-> readdata[`LTA_EXP_HI:`LTA_EXP_LO] == 4'h0)
        else $error("result exponent not masked");
    exp_pass_read_a: assert property (read && st.wait_bus && address == `LTA_OFF_RESULT
                                      && !(st.emask && st.range_number < `LTA_RANGE_AUTO)
                                      ##1 !waitrequest
                                      |-> readdata[`LTA_EXP_HI:0] == $past(st.result))
        else $error("unmasked result read altered");
    mask_keeps_mantissa_a: assert property (read && st.wait_bus
                                            && address == `LTA_OFF_RESULT
                                            ##1 !waitrequest
                                            |-> readdata[`LTA_MAN_HI:0]
                                                == $past(st.result[`LTA_MAN_HI:0]))
        else $error("result mantissa altered on read");
    raw_result_kept_a: assert property (result_valid |=> st.result == $past(result))
        else $error("stored result altered");

    // Fault count and lux compare
    single_count_a: assert property (st.fault_count_sel == 2'h0 && result_valid
                                     && over_fault |=> st.over)
        else $error("one fault did not trip at count code zero");
    under_count_one_a: assert property (st.fault_count_sel == 2'h0 && result_valid
                                        && under_fault |=> st.under)
        else $error("one low fault did not trip at count code zero");
    lux_equal_a: assert property (result_valid && res_lux == high_lux |-> !over_fault)
        else $error("equal lux counted as over");
    over_same_exp_a: assert property (result_valid && st.fault_count_sel == 2'h0
                                      && result[`LTA_EXP_HI:`LTA_EXP_LO]
                                         == st.high[`LTA_EXP_HI:`LTA_EXP_LO]
                                      && result[`LTA_MAN_HI:0] > st.high[`LTA_MAN_HI:0]
                                      |=> st.over)
        else $error("over compare wrong for equal exponents");
    under_same_exp_a: assert property (result_valid && st.fault_count_sel == 2'h0
                                       && result[`LTA_EXP_HI:`LTA_EXP_LO]
                                          == st.low[`LTA_EXP_HI:`LTA_EXP_LO]
                                       && result[`LTA_MAN_HI:0] < st.low[`LTA_MAN_HI:0]
                                       |=> st.under)
        else $error("under compare wrong for equal exponents");

    // Register bus and interrupt
    bus_answer_a: assert property (req && waitrequest |=> !waitrequest)
        else $error("slave did not answer in one wait cycle");
    wait_idle_a: assert property (!req |=> waitrequest)
        else $error("wait request low without a request");
    setup_write_a: assert property (accept && write && address == `LTA_OFF_SETUP && byteenable[0]
                                    |=> st.sticky == $past(writedata[`LTA_STICKY_BIT]))
        else $error("setup write did not land");
    mask_write_a: assert property (accept && write && address == `LTA_OFF_MASK && byteenable[0]
                                   |=> st.irq_mask == $past(writedata[`LTA_IRQ_W-1:0]))
        else $error("mask write did not land");
    irq_level_a: assert property (st.irq == |(st.irq_stat & st.irq_mask))
        else $error("interrupt level does not match unmasked status");

    // Main scenarios
    over_latched_c: cover property (st.sticky && over_trip ##1 st.over);
    under_hyst_c: cover property (!st.sticky && under_trip ##[1:20] !st.under);
    irq_raise_c: cover property (!st.irq ##1 st.irq);
    masked_read_c: cover property (accept && read && st.emask
                                   && st.range_number < `LTA_RANGE_AUTO);
    fault_eight_c: cover property (st.fault_count_sel == 2'h3 && under_trip);
endmodule

// ===== lta_host_model.sv
// Host side of the open-drain alert pin: resolves the wire with its pull-up.
// Assumes the device drives alert_out onto the wire while alert_oe is high.
module lta_host_model
    import lta_pkg::*;
(
    // Device pin
    input wire logic alert_out,
    input wire logic alert_oe,
    // Level the host sees
    output logic alert_pin
);
    // A released wire floats up to the pull-up level
    assign alert_pin = alert_oe ? alert_out : 1'b1;
endmodule

// ===== test_lta_top.sv
// Testbench of lta_top: register reset values, threshold rows, sticky, mask and interrupt cases.
// Assumes the design files and lta_host_model are compiled before it.
`include "lta_cfg.svh"

module test_lta_top
    import lta_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [15:0] setup;
        logic [15:0] word;
        int n;
        logic [2:0] out;
    } lta_row_t;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h3;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest;
    logic [15:0] result = 16'h0000;
    logic result_valid = 1'b0;
    logic over_threshold_hit;
    logic under_threshold_hit;
    logic irq;
    logic alert_out;
    logic alert_oe;
    logic alert_pin;
    logic [31:0] q;
    int err_total = 0;
    int n_tests = 0;
    // Columns: setup, result word, conversions, {over, under, pin level}
    lta_row_t rows [15] = '{
        '{16'hc000, 16'h0201, 1, 3'b100}, '{16'hc000, 16'h0200, 1, 3'b001},
        '{16'hc000, 16'h1101, 1, 3'b100},
        '{16'hc000, 16'h2081, 1, 3'b100}, '{16'hc000, 16'h3040, 1, 3'b001},
        '{16'hc000, 16'h007f, 1, 3'b010}, '{16'hc000, 16'h1040, 1, 3'b001},
        '{16'hc001, 16'h103f, 1, 3'b001}, '{16'hc001, 16'h103f, 2, 3'b010},
        '{16'hc002, 16'h0201, 3, 3'b001}, '{16'hc002, 16'h0201, 4, 3'b100},
        '{16'hc003, 16'h0201, 7, 3'b001}, '{16'hc003, 16'h007f, 8, 3'b010},
        '{16'hc008, 16'h0201, 1, 3'b101}, '{16'hc008, 16'h0100, 1, 3'b000}
    };

    always #2.5 core_clk = ~core_clk;

    lta_top dut (
        .core_clk(core_clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .result(result), .result_valid(result_valid),
        .over_threshold_hit(over_threshold_hit), .under_threshold_hit(under_threshold_hit),
        .irq(irq), .alert_out(alert_out), .alert_oe(alert_oe)
    );

    lta_host_model host (.alert_out(alert_out), .alert_oe(alert_oe), .alert_pin(alert_pin));

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s, got %h", $time, msg, got);
        end
    endtask

    // One Avalon access; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (waitrequest === 1'b0) break;
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (i == 20) begin
            err_total++;
            $display("wrong value at %0t: no bus answer", $time);
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, 32'h00000000);
        chk(q, exp, msg);
    endtask

    // n conversions of one word, each a one-cycle pulse, then settle to the falling edge
    task automatic conv(input logic [15:0] w, input int n);
        repeat (n) begin
            @(posedge core_clk);
            result <= w;
            result_valid <= 1'b1;
            @(posedge core_clk);
            result_valid <= 1'b0;
        end
        @(negedge core_clk);
    endtask

    task automatic flags(input logic [2:0] e, input string msg);
        chk({29'h0, over_threshold_hit, under_threshold_hit, alert_pin}, {29'h0, e}, msg);
    endtask

    initial begin
        int k;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`LTA_OFF_SETUP, 32'h0000c010, "setup after reset");
        rd(`LTA_OFF_LOW, 32'h00000000, "low after reset");
        rd(`LTA_OFF_HIGH, 32'h0000bfff, "high after reset");
        rd(`LTA_OFF_IDENT, `LTA_IDENT_VAL, "ident");
        wr(8'h1c, 32'h0000ffff);
        rd(8'h1c, 32'h00000000, "unmapped");
        flags(3'b001, "pins after reset");
        $display("test reset done");
        // Limits: low 0x80 lux units, high 0x200 lux units
        wr(`LTA_OFF_LOW, 32'h00000080);
        wr(`LTA_OFF_HIGH, 32'h00001100);
        for (k = 0; k < $size(rows); k++) begin
            wr(`LTA_OFF_SETUP, {16'h0000, rows[k].setup});
            conv(16'h0100, 1);
            conv(rows[k].word, rows[k].n);
            flags(rows[k].out, "threshold row");
        end
        $display("test rows done");
        wr(`LTA_OFF_SETUP, 32'h0000c001);
        conv(16'h0201, 1);
        conv(16'h0100, 1);
        conv(16'h0201, 1);
        flags(3'b001, "broken fault run");
        conv(16'h0201, 1);
        flags(3'b100, "fault run resumed");
        $display("test restart done");
        wr(`LTA_OFF_SETUP, 32'h0000c010);
        conv(16'h0201, 1);
        conv(16'h0100, 2);
        flags(3'b100, "sticky hold");
        rd(`LTA_OFF_SETUP, 32'h0000c050, "sticky read");
        repeat (2) @(negedge core_clk);
        flags(3'b001, "sticky cleared");
        $display("test sticky done");
        wr(`LTA_OFF_SETUP, 32'h00005004);
        conv(16'h2081, 1);
        flags(3'b100, "unmasked compare");
        rd(`LTA_OFF_RESULT, 32'h00000081, "masked exponent");
        wr(`LTA_OFF_SETUP, 32'h0000c004);
        rd(`LTA_OFF_RESULT, 32'h00002081, "auto range exponent");
        $display("test mask done");
        wr(`LTA_OFF_MASK, 32'h00000000);
        wr(`LTA_OFF_STAT, 32'h00000007);
        rd(`LTA_OFF_STAT, 32'h00000000, "status cleared");
        conv(16'h007f, 1);
        rd(`LTA_OFF_STAT, 32'h00000006, "under status");
        chk({31'h0, irq}, 32'h00000000, "masked irq");
        wr(`LTA_OFF_MASK, 32'h00000002);
        repeat (2) @(negedge core_clk);
        chk({31'h0, irq}, 32'h00000001, "unmasked irq");
        wr(`LTA_OFF_STAT, 32'h00000002);
        repeat (2) @(negedge core_clk);
        chk({31'h0, irq}, 32'h00000000, "irq after clear");
        rd(`LTA_OFF_STAT, 32'h00000004, "status after clear");
        $display("test irq done");
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        flags(3'b001, "pins after mid-run reset");
        chk({31'h0, irq}, 32'h00000000, "irq after mid-run reset");
        rd(`LTA_OFF_SETUP, 32'h0000c010, "setup after mid-run reset");
        rd(`LTA_OFF_STAT, 32'h00000000, "status after mid-run reset");
        rd(`LTA_OFF_MASK, 32'h00000000, "mask after mid-run reset");
        $display("test mid-run reset done");
        stop_test();
    end
endmodule
